//--- include/rfoag_pkg.sv
// Shared constants and carrier types for the operand address generator
package rfoag_pkg;

   // Address width of one register file port
   localparam int unsigned RFOAG_AW = 6;
   localparam logic [5:0] RFOAG_ADDR_MIN = 6'h00;
   localparam logic [5:0] RFOAG_ADDR_MAX = 6'h3F;

   // Macro opcode register field positions (start values, position, width)
   localparam int unsigned RFOAG_MOP_A_LSB = 0;
   localparam int unsigned RFOAG_MOP_B_LSB = 6;
   localparam int unsigned RFOAG_MOP_C_LSB = 12;
   localparam int unsigned RFOAG_MOP_POS_LSB = 24;
   localparam int unsigned RFOAG_MOP_WID_LSB = 18;

   // Register byte offsets on the bus
   localparam logic [7:0] RFOAG_OFS_CTRL = 8'h00;
   localparam logic [7:0] RFOAG_OFS_CNT = 8'h04;
   localparam logic [7:0] RFOAG_OFS_ADDR = 8'h08;

   // Control register layout and reset value
   localparam int unsigned RFOAG_CTRL_RUN_BIT = 0;
   localparam logic [31:0] RFOAG_CTRL_RST = 32'h0000_0001;

   // Status field positions (byte lanes)
   localparam int unsigned RFOAG_ST_F0 = 0;
   localparam int unsigned RFOAG_ST_F1 = 8;
   localparam int unsigned RFOAG_ST_F2 = 16;
   localparam int unsigned RFOAG_ST_F3 = 24;

   // AHB transfer type and response codes
   localparam logic [1:0] RFOAG_HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Counter function codes
   typedef enum logic [1:0] {
      RFOAG_CNT_HOLD = 2'h0,
      RFOAG_CNT_LOAD = 2'h1,
      RFOAG_CNT_UP = 2'h2,
      RFOAG_CNT_DOWN = 2'h3
   } rfoag_cfn_e;

   // Write port A source codes
   typedef enum logic [1:0] {
      RFOAG_WA_PIPE = 2'h0,
      RFOAG_WA_CNT = 2'h1,
      RFOAG_WA_RDA = 2'h2,
      RFOAG_WA_RDB = 2'h3
   } rfoag_wasel_e;

   // Per-counter control coming from the control pipeline
   typedef struct packed {
      logic oe;
      rfoag_cfn_e fn;
   } rfoag_cctl_s;

   // Control pipeline register fields used by this block
   typedef struct packed {
      logic [5:0] a_addr;
      logic [5:0] b_addr;
      logic [5:0] c_addr;
      logic [5:0] pos;
      logic [5:0] wid;
      logic a_sel;
      logic b_sel;
      rfoag_wasel_e wa_sel;
      logic wb_sel;
      logic pw_sel;
      rfoag_cctl_s cnt_a;
      rfoag_cctl_s cnt_b;
      rfoag_cctl_s cnt_c;
   } rfoag_pipe_s;

   // Port addresses toward the register file
   typedef struct packed {
      logic [5:0] rd_a;
      logic [5:0] rd_b;
      logic [5:0] wr_a;
      logic [5:0] wr_b;
   } rfoag_rfaddr_s;

endpackage : rfoag_pkg

//--- rtl/rfoag_counter.sv
// Loadable up/down operand counter with wrap to start value
`timescale 1ns/1ps
`default_nettype none
module rfoag_counter #(
   parameter int unsigned AW = 6
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire rfoag_pkg::rfoag_cctl_s ctl,
   input wire logic run,
   input wire logic [AW-1:0] start,
   // Count
   output logic [AW-1:0] cnt,
   output logic [AW-1:0] q
);
   import rfoag_pkg::*;

   // Wrap bounds are fixed at the six-bit address range, so refuse any other width
   if (AW != RFOAG_AW) begin : g_bad_aw
      $error("rfoag_counter: AW must equal register file address width");
   end

   logic [AW-1:0] cnt_r;
   logic [AW-1:0] cnt_nxt;
   logic at_max;
   logic at_min;
   logic step_up;
   logic step_dn;

   // Function decode from the pipeline control
   assign step_up = run && (ctl.fn == RFOAG_CNT_UP); // (R12)
   assign step_dn = run && (ctl.fn == RFOAG_CNT_DOWN); // (R12)
   assign at_max = (cnt_r == AW'(RFOAG_ADDR_MAX)); // (R2)
   assign at_min = (cnt_r == AW'(RFOAG_ADDR_MIN)); // (R2)

   // Next count: a step off either bound reloads the opcode start value
   assign cnt_nxt = (ctl.fn == RFOAG_CNT_LOAD) ? start : // (R11)
      (step_up && at_max) ? start : // (R1)
      (step_dn && at_min) ? start : // (R1)
      step_up ? AW'(cnt_r + AW'(1)) :
      step_dn ? AW'(cnt_r - AW'(1)) : cnt_r;

   // Count register, rising edge only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt; // (R13)
      end
   end

   assign cnt = cnt_r;
   // Disabled output reads zero, like an undriven bus pulled low
   assign q = ctl.oe ? cnt_r : '0; // (R12)

   property p_wrap_up;
      @(posedge hclk) disable iff (!hresetn)
      (step_up && at_max && ctl.fn != RFOAG_CNT_LOAD) |=> (cnt_r == $past(start));
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("up wrap did not reload start"); // (R1)

   property p_wrap_dn;
      @(posedge hclk) disable iff (!hresetn)
      (step_dn && at_min) |=> (cnt_r == $past(start));
   endproperty
   a_wrap_dn: assert property (p_wrap_dn) else $error("down wrap did not reload start"); // (R2)

   property p_load;
      @(posedge hclk) disable iff (!hresetn)
      (ctl.fn == RFOAG_CNT_LOAD) |=> (cnt_r == $past(start));
   endproperty
   a_load: assert property (p_load) else $error("load did not take start value"); // (R11)

   property p_step;
      @(posedge hclk) disable iff (!hresetn)
      (step_up && !at_max) |=> (cnt_r == AW'($past(cnt_r) + AW'(1)));
   endproperty
   a_step: assert property (p_step) else $error("increment step wrong"); // (R12)

endmodule : rfoag_counter
`default_nettype wire

//--- rtl/rfoag_top.sv
// Register file operand address generator with AHB-Lite status and control
// How it works
// (R1) A counter stepping off its top or bottom count reloads its start value from the opcode.
// (R2) The wrap bounds are address 0 at the bottom and 63 at the top.
// (R3) Every operand address leaving the block is six bits wide.
// (R4) Read addresses A and B each come from the pipeline field or their counter by one bit.
// (R5) Write port A takes the pipeline C field, the C counter, final read A or final read B.
// (R6) Read A and B feeding the write port A selector are the already selected addresses.
// (R7) The microcode supplies the two write port A select bits in the pipeline register.
// (R8) Write port B takes the pipeline C field or the C counter under one select bit.
// (R9) Position and width for the ALU each pick the pipeline or the opcode register.
// (R10) The microcode supplies the position and width select in the pipeline register.
// (R11) A counter loads its start value from the opcode register when told to load.
// (R12) Each counter decodes load, direction, output enable and count enable itself.
// (R13) Counters change on the rising clock only; all selectors are combinational.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rfoag_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Control pipeline and macro opcode register
   input wire rfoag_pkg::rfoag_pipe_s pipe,
   input wire logic [31:0] mop,
   // Toward register file and ALU
   output var rfoag_pkg::rfoag_rfaddr_s rf_addr,
   output logic [5:0] alu_pos,
   output logic [5:0] alu_wid
);
   import rfoag_pkg::*;

   // Six-bit field from the opcode register
   function automatic logic [5:0] mop_field(input logic [31:0] w, input int unsigned lsb);
      logic [31:0] s;
      s = w >> lsb;
      return s[5:0];
   endfunction : mop_field

   // Two-way six-bit selector
   function automatic logic [5:0] sel2(input logic s, input logic [5:0] a, input logic [5:0] b);
      return s ? b : a;
   endfunction : sel2

   logic [5:0] cnt_a;
   logic [5:0] cnt_b;
   logic [5:0] cnt_c;
   logic [5:0] q_a;
   logic [5:0] q_b;
   logic [5:0] q_c;
   logic [5:0] rd_a;
   logic [5:0] rd_b;
   logic [5:0] wr_a;
   logic [5:0] wr_b;
   logic [31:0] ctrl_r;
   logic run;

   assign run = ctrl_r[RFOAG_CTRL_RUN_BIT];

   // Three identical operand counters
   rfoag_counter #(.AW(RFOAG_AW)) u_cnt_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(pipe.cnt_a),
      .run(run),
      .start(mop_field(mop, RFOAG_MOP_A_LSB)), // (R11)
      .cnt(cnt_a),
      .q(q_a)
   );
   rfoag_counter #(.AW(RFOAG_AW)) u_cnt_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(pipe.cnt_b),
      .run(run),
      .start(mop_field(mop, RFOAG_MOP_B_LSB)), // (R11)
      .cnt(cnt_b),
      .q(q_b)
   );
   rfoag_counter #(.AW(RFOAG_AW)) u_cnt_c (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(pipe.cnt_c),
      .run(run),
      .start(mop_field(mop, RFOAG_MOP_C_LSB)), // (R11)
      .cnt(cnt_c),
      .q(q_c)
   );

   // Address selectors; kept combinational so addresses follow the pipeline in-cycle
   assign rd_a = sel2(pipe.a_sel, pipe.a_addr, q_a); // (R4)
   assign rd_b = sel2(pipe.b_sel, pipe.b_addr, q_b); // (R4)
   assign wr_a = (pipe.wa_sel == RFOAG_WA_PIPE) ? pipe.c_addr : // (R5)
      (pipe.wa_sel == RFOAG_WA_CNT) ? q_c :
      (pipe.wa_sel == RFOAG_WA_RDA) ? rd_a : rd_b; // (R6)
   assign wr_b = sel2(pipe.wb_sel, pipe.c_addr, q_c); // (R8)
   assign rf_addr = '{rd_a: rd_a, rd_b: rd_b, wr_a: wr_a, wr_b: wr_b}; // (R3)

   // Position and width toward the ALU, on its critical path
   assign alu_pos = sel2(pipe.pw_sel, pipe.pos, mop_field(mop, RFOAG_MOP_POS_LSB)); // (R9)
   assign alu_wid = sel2(pipe.pw_sel, pipe.wid, mop_field(mop, RFOAG_MOP_WID_LSB)); // (R9)

   // Bus slave: zero wait states, so every data phase is one cycle
   logic ap_valid;
   logic dp_wr_r;
   logic [7:0] dp_addr_r;
   logic [31:0] rd_val;
   logic [31:0] cnt_word;
   logic [31:0] addr_word;

   assign ap_valid = hsel && hready && (htrans == RFOAG_HTRANS_NONSEQ);
   assign cnt_word = {8'h00, 2'h0, cnt_c, 2'h0, cnt_b, 2'h0, cnt_a};
   assign addr_word = {2'h0, wr_b, 2'h0, wr_a, 2'h0, rd_b, 2'h0, rd_a};
   // Unmapped offsets read zero and ignore writes
   assign rd_val = (haddr[7:0] == RFOAG_OFS_CTRL) ? ctrl_r :
      (haddr[7:0] == RFOAG_OFS_CNT) ? cnt_word :
      (haddr[7:0] == RFOAG_OFS_ADDR) ? addr_word : 32'h0000_0000;

   // Address phase capture and read data, sampled at the address edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         dp_wr_r <= ap_valid && hwrite;
         dp_addr_r <= haddr[7:0];
         hrdata <= (ap_valid && !hwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // Control register write in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= RFOAG_CTRL_RST;
      end else if (dp_wr_r && dp_addr_r == RFOAG_OFS_CTRL) begin
         ctrl_r <= {31'h0000_0000, hwdata[RFOAG_CTRL_RUN_BIT]};
      end
   end

   // Ready from the first edge after reset, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   property p_rd_a;
      @(posedge hclk) disable iff (!hresetn)
      rf_addr.rd_a == (pipe.a_sel ? q_a : pipe.a_addr);
   endproperty
   a_rd_a: assert property (p_rd_a) else $error("read A source wrong"); // (R4)

   property p_rd_b;
      @(posedge hclk) disable iff (!hresetn)
      (pipe.b_sel && pipe.cnt_b.oe) |-> (rf_addr.rd_b == cnt_b);
   endproperty
   a_rd_b: assert property (p_rd_b) else $error("read B not from counter"); // (R4)

   property p_wa_final;
      @(posedge hclk) disable iff (!hresetn)
      (pipe.wa_sel == RFOAG_WA_RDB) |-> (rf_addr.wr_a == rf_addr.rd_b);
   endproperty
   a_wa_final: assert property (p_wa_final) else $error("write A not final B"); // (R6)

   property p_wa_cnt;
      @(posedge hclk) disable iff (!hresetn)
      (pipe.wa_sel == RFOAG_WA_CNT && pipe.cnt_c.oe) |-> (rf_addr.wr_a == cnt_c);
   endproperty
   a_wa_cnt: assert property (p_wa_cnt) else $error("write A not from C counter"); // (R5)

   property p_wb;
      @(posedge hclk) disable iff (!hresetn)
      (!pipe.wb_sel) |-> (rf_addr.wr_b == pipe.c_addr);
   endproperty
   a_wb: assert property (p_wb) else $error("write B not from pipeline"); // (R8)

   property p_pw;
      @(posedge hclk) disable iff (!hresetn)
      pipe.pw_sel |-> (alu_pos == mop[29:24] && alu_wid == mop[23:18]);
   endproperty
   a_pw: assert property (p_pw) else $error("position or width not from opcode"); // (R9)

   property p_cnt_stop;
      @(posedge hclk) disable iff (!hresetn)
      (!run && pipe.cnt_a.fn != RFOAG_CNT_LOAD) |=> $stable(cnt_a);
   endproperty
   a_cnt_stop: assert property (p_cnt_stop) else $error("counter moved while stopped"); // (R13)

   property p_ctrl_wr;
      @(posedge hclk) disable iff (!hresetn)
      (ap_valid && hwrite && haddr[7:0] == RFOAG_OFS_CTRL) ##1 1'b1
      |=> (ctrl_r[0] == $past(hwdata[0]));
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // (R12)

endmodule : rfoag_top
`default_nettype wire

//--- dv/rfoag_pipe_model.sv
// Control pipeline and macro opcode register model feeding the generator
`timescale 1ns/1ps
`default_nettype none
module rfoag_pipe_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Next microword and opcode from the sequencer side
   input wire rfoag_pkg::rfoag_pipe_s nxt_pipe,
   input wire logic [31:0] nxt_mop,
   // Registered fields toward the generator
   output var rfoag_pkg::rfoag_pipe_s pipe,
   output logic [31:0] mop
);
   import rfoag_pkg::*;
   rfoag_pipe_s pipe_r;
   logic [31:0] mop_r;
   // Whole microword registered, so selects only ever move at an edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pipe_r <= '0; // Hold functions, pipeline sources
         mop_r <= 32'h0000_0000;
      end else begin
         pipe_r <= nxt_pipe;
         mop_r <= nxt_mop;
      end
   end
   // Outputs straight from the flops
   assign pipe = pipe_r;
   assign mop = mop_r;
endmodule : rfoag_pipe_model
`default_nettype wire

//--- dv/test_rfoag_top.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module test_rfoag_top;
   import rfoag_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, nxt_mop, mop, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   rfoag_pipe_s nxt_pipe, pipe, p;
   rfoag_rfaddr_s rf_addr;
   logic [5:0] alu_pos, alu_wid;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;

   // Microword source; selects reach the generator one edge after the bench
   rfoag_pipe_model u_pipe (.hclk(hclk), .hresetn(hresetn), .nxt_pipe(nxt_pipe),
      .nxt_mop(nxt_mop), .pipe(pipe), .mop(mop));
   // Single slave, so its ready is the bus ready
   rfoag_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pipe(pipe), .mop(mop),
      .rf_addr(rf_addr), .alu_pos(alu_pos), .alu_wid(alu_wid));

   // 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Hang guard, well beyond the roughly 80 cycles needed
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up;
      end
   end

   task wrap_up;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One word transfer; entered just after a rising edge, waits on ready
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= RFOAG_HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      check({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask : ahb

   // Microword pv drives exactly n counter edges
   task go(input rfoag_pipe_s pv, input int n);
      nxt_pipe <= pv;
      repeat (n) @(posedge hclk);
   endtask : go

   task t_regs;
      ahb(1'b0, RFOAG_OFS_CTRL, 32'h0);
      check(rd, RFOAG_CTRL_RST);
      ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h0C, 32'h0);
      check(rd, 32'h0);
   endtask : t_regs

   // Up counter from 62 and down counter from 1 both cross their bound
   task t_wrap;
      nxt_mop <= {2'h0, 6'h2C, 6'h15, 6'h05, 6'h01, 6'h3E};
      p = '0;
      p.cnt_a.fn = RFOAG_CNT_LOAD;
      p.cnt_b.fn = RFOAG_CNT_LOAD;
      p.cnt_c.fn = RFOAG_CNT_LOAD;
      go(p, 1);
      p.cnt_a.fn = RFOAG_CNT_UP;
      p.cnt_b.fn = RFOAG_CNT_DOWN;
      p.cnt_c.fn = RFOAG_CNT_HOLD;
      go(p, 3);
      p = '0;
      go(p, 1);
      ahb(1'b0, RFOAG_OFS_CNT, 32'h0);
      check(rd, 32'h0005_003F);
   endtask : t_wrap

   // Steps frozen while run is clear
   task t_run;
      ahb(1'b1, RFOAG_OFS_CTRL, 32'h0);
      p.cnt_a.fn = RFOAG_CNT_UP;
      // One up step at A=3F; a counter that ignored run would wrap to 3E
      go(p, 1);
      p = '0;
      go(p, 1);
      ahb(1'b0, RFOAG_OFS_CNT, 32'h0);
      check(rd, 32'h0005_003F);
      ahb(1'b1, RFOAG_OFS_CTRL, 32'h1);
   endtask : t_run

   // Sixteen select combinations, wb_sel and pw_sel tied to the wa_sel bits, counters at A=3F B=00 C=05
   task t_sel;
      logic [5:0] ea, eb, ec, ew;
      for (int i = 0; i < 16; i++) begin
         p = '0;
         p.a_addr = 6'h11;
         p.b_addr = 6'h22;
         p.c_addr = 6'h33;
         p.pos = 6'h0A;
         p.wid = 6'h0B;
         p.a_sel = i[0];
         p.b_sel = i[1];
         p.wa_sel = rfoag_wasel_e'(i[3:2]);
         p.wb_sel = i[2];
         p.pw_sel = i[3];
         p.cnt_a.oe = 1'b1;
         p.cnt_b.oe = 1'b1;
         p.cnt_c.oe = (i != 15);
         go(p, 1);
         #1;
         ea = p.a_sel ? 6'h3F : 6'h11;
         eb = p.b_sel ? 6'h00 : 6'h22;
         ec = p.cnt_c.oe ? 6'h05 : 6'h00;
         case (p.wa_sel)
            RFOAG_WA_PIPE: ew = 6'h33;
            RFOAG_WA_CNT: ew = ec;
            RFOAG_WA_RDA: ew = ea;
            default: ew = eb;
         endcase
         check({8'h00, rf_addr}, {8'h00, ea, eb, ew, (p.wb_sel ? ec : 6'h33)});
         check({20'h0, alu_pos, alu_wid},
            {20'h0, (p.pw_sel ? 6'h2C : 6'h0A), (p.pw_sel ? 6'h15 : 6'h0B)});
         @(posedge hclk);
         // Address register mirrors the live port addresses
         if (i == 9) begin
            ahb(1'b0, RFOAG_OFS_ADDR, 32'h0);
            check(rd, {2'h0, (p.wb_sel ? ec : 6'h33), 2'h0, ew, 2'h0, eb, 2'h0, ea});
         end
      end
   endtask : t_sel

   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      nxt_pipe = '0;
      nxt_mop = 32'h0;
      p = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_regs;
      t_wrap;
      t_run;
      t_sel;
      wrap_up;
   end
endmodule : test_rfoag_top
`default_nettype wire
